// ---- slp_stack_limit.sv ----
// slp_stack_limit: software stack pointer, limit and floor checking,
// stack error trap, and program-space address building.
// assumes: the core issues at most one stack request per cycle and keeps
// software ordering between limit writes and stack reads.
`timescale 1ns/1ps

module slp_stack_limit (
	// clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    reset_n_i,
	// register port
	input  wire logic [3:0]              reg_addr_i,
	input  wire logic [15:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [15:0]                  reg_rdata_o,
	// stack requests from the core
	input  wire slp_pkg::slp_stack_req_t stack_req_i,
	output slp_pkg::slp_stack_acc_t      stack_acc_o,
	output logic                         stack_trap_o,
	// program-space requests from the core
	input  wire slp_pkg::slp_prog_req_t  prog_req_i,
	input  wire logic                    table_busy_i,
	output slp_pkg::slp_prog_out_t       prog_res_o
);
	import slp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0] limit_reg;
	logic [15:0] sp_reg;
	logic [15:0] sp_next;
	logic [7:0]  tpage_reg;
	logic [7:0]  vpage_reg;
	logic [15:0] core_reg;
	logic [7:0]  stlow_reg;
	logic [1:0]  err_reg;
	logic [1:0]  err_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	slp_stack_acc_t acc_reg;
	slp_stack_acc_t acc_next;
	logic        trap_reg;

	////////////////////////////////////////////////////////////////////////
	// decode

	wire wr_limit  = reg_wr_i && reg_addr_i == SLP_OFS_LIMIT;
	wire wr_sp     = reg_wr_i && reg_addr_i == SLP_OFS_SP;
	wire wr_tpage  = reg_wr_i && reg_addr_i == SLP_OFS_TPAGE;
	wire wr_vpage  = reg_wr_i && reg_addr_i == SLP_OFS_VPAGE;
	wire wr_core   = reg_wr_i && reg_addr_i == SLP_OFS_CORE;
	wire wr_stlow  = reg_wr_i && reg_addr_i == SLP_OFS_STLOW;
	wire wr_err    = reg_wr_i && reg_addr_i == SLP_OFS_ERR;

	wire op_push = stack_req_i.valid && (stack_req_i.op == SLP_OP_PUSH ||
	               stack_req_i.op == SLP_OP_PUSH_CALL_HI ||
	               stack_req_i.op == SLP_OP_PUSH_EXC_HI);
	wire op_pop  = stack_req_i.valid && stack_req_i.op == SLP_OP_POP;
	wire op_ea   = stack_req_i.valid && stack_req_i.op == SLP_OP_EA;

	wire [15:0] sp_dec = sp_reg - SLP_SP_STEP;
	wire [15:0] sp_inc = sp_reg + SLP_SP_STEP;

	// address the access uses
	logic [15:0] acc_addr;
	always_comb begin
		acc_addr = stack_req_i.data;
		if (op_push) begin
			acc_addr = sp_reg;
		end else if (op_pop) begin
			acc_addr = sp_dec;
		end
	end

	// word written by a push
	logic [15:0] push_word;
	always_comb begin
		case (stack_req_i.op)
			SLP_OP_PUSH_CALL_HI: push_word = {8'h00, stack_req_i.pc_hi};
			SLP_OP_PUSH_EXC_HI:  push_word = {stlow_reg, stack_req_i.pc_hi};
			default:             push_word = stack_req_i.data;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// limit and floor checks

	wire chk_any  = op_push | op_pop | op_ea;
	wire over_lim = (op_push | op_ea) && (acc_addr > limit_reg);
	wire under_fl = chk_any && (acc_addr < SLP_SP_FLOOR);
	wire trap_now = over_lim | under_fl;

	always_comb begin
		sp_next = sp_reg;
		if (op_push) begin
			sp_next = sp_inc;
		end else if (op_pop) begin
			sp_next = sp_dec;
		end else if (wr_sp) begin
			sp_next = {reg_wdata_i[15:1], 1'b0};
		end
	end

	always_comb begin
		acc_next       = '0;
		acc_next.valid = op_push | op_pop;
		acc_next.write = op_push;
		acc_next.read  = op_pop;
		acc_next.addr  = acc_addr;
		acc_next.wdata = op_push ? push_word : 16'h0000;
	end

	// sticky error flags, set wins over software clear
	always_comb begin
		err_next = err_reg;
		if (wr_err) begin
			err_next = err_reg & ~reg_wdata_i[1:0];
		end
		if (over_lim) begin
			err_next[SLP_ERR_OVF_BIT] = 1'b1;
		end
		if (under_fl) begin
			err_next[SLP_ERR_UDF_BIT] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		case (reg_addr_i)
			SLP_OFS_LIMIT:  rdata_next = limit_reg;
			SLP_OFS_SP:     rdata_next = sp_reg;
			SLP_OFS_TPAGE:  rdata_next = {8'h00, tpage_reg};
			SLP_OFS_VPAGE:  rdata_next = {8'h00, vpage_reg};
			SLP_OFS_CORE:   rdata_next = core_reg;
			SLP_OFS_STLOW:  rdata_next = {8'h00, stlow_reg};
			SLP_OFS_ERR:    rdata_next = {14'h0000, err_reg};
			default:        rdata_next = 16'h0000;
		endcase
		if (!reg_rd_i) begin
			rdata_next = 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flip-flops

	// stack limit keeps whatever it holds across reset
	always_ff @(posedge core_clk_i) begin
		if (wr_limit) begin
			limit_reg <= {reg_wdata_i[15:1], 1'b0};
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sp_reg   <= SLP_SP_RESET;
			err_reg  <= 2'h0;
			acc_reg  <= '0;
			trap_reg <= 1'b0;
		end else begin
			sp_reg   <= sp_next;
			err_reg  <= err_next;
			acc_reg  <= acc_next;
			trap_reg <= trap_now;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tpage_reg  <= SLP_PAGE_RESET;
			vpage_reg  <= SLP_PAGE_RESET;
			core_reg   <= SLP_CORE_RESET;
			stlow_reg  <= SLP_STLOW_RST;
		end else begin
			if (wr_tpage) begin
				tpage_reg <= reg_wdata_i[7:0];
			end
			if (wr_vpage) begin
				vpage_reg <= reg_wdata_i[7:0];
			end
			if (wr_core) begin
				core_reg <= reg_wdata_i;
			end
			if (wr_stlow) begin
				stlow_reg <= reg_wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_o  = rdata_reg;
	assign stack_acc_o  = acc_reg;
	assign stack_trap_o = trap_reg;

	////////////////////////////////////////////////////////////////////////
	// program-space addresses

	slp_prog_addr u_prog_addr (
		.core_clk_i   (core_clk_i),
		.reset_n_i    (reset_n_i),
		.table_page_i (tpage_reg),
		.vis_page_i   (vpage_reg),
		.vis_enable_i (core_reg[SLP_CORE_VIS_BIT]),
		.table_busy_i (table_busy_i),
		.req_i        (prog_req_i),
		.res_o        (prog_res_o)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	push_post_inc_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		op_push |=> sp_reg == $past(sp_reg) + 16'h0002 &&
		             stack_acc_o.addr == $past(sp_reg) && stack_acc_o.write)
		else $error("push did not write at pointer then increment");

	pop_pre_dec_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		op_pop |=> sp_reg == $past(sp_reg) - 16'h0002 &&
		            stack_acc_o.addr == sp_reg && stack_acc_o.read)
		else $error("pop did not decrement before access");

	call_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(stack_req_i.valid && stack_req_i.op == SLP_OP_PUSH_CALL_HI)
		|=> stack_acc_o.wdata[15:8] == 8'h00)
		else $error("call push upper byte not clear");

	exc_status_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(stack_req_i.valid && stack_req_i.op == SLP_OP_PUSH_EXC_HI)
		|=> stack_acc_o.wdata[15:8] == $past(stlow_reg))
		else $error("exception push lacks status byte");

	limit_align_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$past(wr_limit) |-> limit_reg[0] == 1'b0)
		else $error("stack limit bit zero set");

	limit_equal_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(op_push && sp_reg == limit_reg && sp_reg >= SLP_SP_FLOOR)
		##1 (op_push && !wr_sp) |-> !stack_trap_o ##1 stack_trap_o)
		else $error("limit trap not on the push after the limit");

	floor_trap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(chk_any && acc_addr < SLP_SP_FLOOR) |=> stack_trap_o &&
		err_reg[SLP_ERR_UDF_BIT])
		else $error("underflow did not trap");

	ea_check_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(op_ea && stack_req_i.data > limit_reg) |=> stack_trap_o &&
		err_reg[SLP_ERR_OVF_BIT])
		else $error("explicit address over limit did not trap");

	no_false_trap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!stack_req_i.valid |=> !stack_trap_o)
		else $error("trap without a stack request");

	read_timing_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_rd_i && reg_addr_i == SLP_OFS_SP && !op_push && !op_pop)
		|=> reg_rdata_o == $past(sp_reg))
		else $error("pointer read data wrong");

	push_cov_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
		op_push ##1 op_push ##1 op_pop);
	ovf_cov_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
		over_lim);
	udf_cov_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
		under_fl);

endmodule : slp_stack_limit

// ---- slp_pkg.sv ----
// slp_pkg: constants, types and register map for stack checking and
// program-space address building.
// assumes: a 16-bit core drives the request structs on core_clk_i.
package slp_pkg;

	// register map, byte offsets on the plain register port
	localparam logic [3:0] SLP_OFS_LIMIT  = 4'h0;
	localparam logic [3:0] SLP_OFS_SP     = 4'h2;
	localparam logic [3:0] SLP_OFS_TPAGE  = 4'h4;
	localparam logic [3:0] SLP_OFS_VPAGE  = 4'h6;
	localparam logic [3:0] SLP_OFS_CORE   = 4'h8;
	localparam logic [3:0] SLP_OFS_STLOW  = 4'ha;
	localparam logic [3:0] SLP_OFS_ERR    = 4'hc;

	// field positions
	localparam int SLP_CORE_VIS_BIT = 2;
	localparam int SLP_ERR_OVF_BIT  = 0;
	localparam int SLP_ERR_UDF_BIT  = 1;
	localparam int SLP_TPAGE_CFG    = 7;
	localparam int SLP_EA_TOP       = 15;

	// values after reset
	localparam logic [15:0] SLP_SP_RESET   = 16'h0800;
	localparam logic [7:0]  SLP_PAGE_RESET = 8'h00;
	localparam logic [15:0] SLP_CORE_RESET = 16'h0000;
	localparam logic [7:0]  SLP_STLOW_RST  = 8'h00;

	// fixed bounds and steps
	localparam logic [15:0] SLP_SP_FLOOR = 16'h0800;
	localparam logic [15:0] SLP_SP_STEP  = 16'h0002;

	// configuration space area that answers table reads
	localparam logic [22:0] SLP_CFG_IMPL_LO = 23'h7f_0000;
	localparam logic [22:0] SLP_CFG_IMPL_HI = 23'h7f_ffff;

	typedef enum logic [2:0] {
		SLP_OP_PUSH,
		SLP_OP_PUSH_CALL_HI,
		SLP_OP_PUSH_EXC_HI,
		SLP_OP_POP,
		SLP_OP_EA
	} slp_op_t;

	typedef struct packed {
		logic        valid;
		slp_op_t     op;
		logic [15:0] data;
		logic [7:0]  pc_hi;
	} slp_stack_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        read;
		logic [15:0] addr;
		logic [15:0] wdata;
	} slp_stack_acc_t;

	typedef struct packed {
		logic        tbl_rd;
		logic        tbl_wr;
		logic        data_rd;
		logic [15:0] ea;
	} slp_prog_req_t;

	typedef struct packed {
		logic        valid;
		logic        cfg;
		logic        remap;
		logic        refused;
		logic        byte_sel;
		logic [23:0] addr;
	} slp_prog_out_t;

endpackage : slp_pkg

// ---- slp_prog_addr.sv ----
// slp_prog_addr: builds program-space addresses from 16-bit data addresses.
// assumes: requests are one-cycle pulses from the core on core_clk_i.
`timescale 1ns/1ps

module slp_prog_addr (
	// clock and reset
	input  wire logic                   core_clk_i,
	input  wire logic                   reset_n_i,
	// page registers and enables
	input  wire logic [7:0]             table_page_i,
	input  wire logic [7:0]             vis_page_i,
	input  wire logic                   vis_enable_i,
	input  wire logic                   table_busy_i,
	// request and result
	input  wire slp_pkg::slp_prog_req_t req_i,
	output slp_pkg::slp_prog_out_t      res_o
);
	import slp_pkg::*;

	slp_prog_out_t res_reg;
	slp_prog_out_t res_next;

	wire       tbl_any     = req_i.tbl_rd | req_i.tbl_wr;
	wire       tbl_cfg     = table_page_i[SLP_TPAGE_CFG];
	wire [23:0] tbl_addr   = {table_page_i, req_i.ea[15:1], 1'b0};
	wire       cfg_in_impl = (tbl_addr[22:0] >= SLP_CFG_IMPL_LO) &&
	                         (tbl_addr[22:0] <= SLP_CFG_IMPL_HI);
	wire       tbl_refuse  = tbl_cfg & (req_i.tbl_wr | ~cfg_in_impl);
	wire       remap_hit   = req_i.data_rd & vis_enable_i & req_i.ea[SLP_EA_TOP] &
	                         ~tbl_any & ~table_busy_i;
	wire [23:0] remap_addr = {1'b0, vis_page_i, req_i.ea[14:1], 1'b0};

	always_comb begin
		res_next          = '0;
		res_next.valid    = tbl_any | remap_hit;
		res_next.byte_sel = req_i.ea[0];
		if (tbl_any) begin
			res_next.addr    = tbl_addr;
			res_next.cfg     = tbl_cfg;
			res_next.refused = tbl_refuse;
		end else if (remap_hit) begin
			res_next.addr  = remap_addr;
			res_next.remap = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			res_reg <= '0;
		end else begin
			res_reg <= res_next;
		end
	end

	assign res_o = res_reg;

	////////////////////////////////////////////////////////////////////////

	remap_user_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		res_reg.remap |-> !res_reg.addr[23] && res_reg.addr[0] == 1'b0)
		else $error("remapped address left user space");

	remap_suspend_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(tbl_any || table_busy_i) |=> !res_reg.remap)
		else $error("remap taken during table access");

	cfg_write_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(req_i.tbl_wr && tbl_cfg) |=> res_reg.refused && res_reg.cfg)
		else $error("table write to configuration space not refused");

	tbl_page_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		tbl_any |=> res_reg.addr[23:16] == $past(table_page_i))
		else $error("table address page wrong");

	remap_cov_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) res_reg.remap);

endmodule : slp_prog_addr

// ---- slp_stack_mem.sv ----
// slp_stack_mem: stack word memory beside the core, answers stack reads.
// assumes: one access a cycle from stack_acc_o, addresses in the low 512 bytes.
`timescale 1ns/1ps

module slp_stack_mem (
	// clock
	input  wire logic                    core_clk_i,
	// access from the block
	input  wire slp_pkg::slp_stack_acc_t acc_i,
	output logic [15:0]                  rdata_o
);
	import slp_pkg::*;

	logic [15:0] mem [0:255];

	// unwritten words hold a per-word pattern, never a stale value
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'h5a5a ^ 16'(i);
		end
	end

	always @(posedge core_clk_i) begin
		if (acc_i.valid && acc_i.write) begin
			mem[acc_i.addr[8:1]] <= acc_i.wdata;
		end
	end

	// read data only while a read stands
	assign rdata_o = (acc_i.valid && acc_i.read) ? mem[acc_i.addr[8:1]] : ~mem[0];
endmodule : slp_stack_mem

// ---- stack_limit_and_program_space_addr_bench.sv ----
// bench for slp_stack_limit: stack pointer, limit, floor and address building.
// assumes: slp_stack_mem stands on the stack access port.
`timescale 1ns/1ps

module stack_limit_and_program_space_addr_bench;
	import slp_pkg::*;

	logic           core_clk_i;
	logic           reset_n_i;
	logic [3:0]     reg_addr_i;
	logic [15:0]    reg_wdata_i;
	logic           reg_wr_i;
	logic           reg_rd_i;
	logic [15:0]    reg_rdata_o;
	slp_stack_req_t stack_req_i;
	slp_stack_acc_t stack_acc_o;
	logic           stack_trap_o;
	slp_prog_req_t  prog_req_i;
	logic           table_busy_i;
	slp_prog_out_t  prog_res_o;
	logic [15:0]    mem_rdata;
	int             bad_count;
	int             total_checks;

	slp_stack_limit DUT (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.stack_req_i(stack_req_i), .stack_acc_o(stack_acc_o),
		.stack_trap_o(stack_trap_o), .prog_req_i(prog_req_i),
		.table_busy_i(table_busy_i), .prog_res_o(prog_res_o)
	);

	slp_stack_mem partner (
		.core_clk_i(core_clk_i), .acc_i(stack_acc_o), .rdata_o(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask : rd

	// one stack request; ed is pushed word or word read back from memory
	task automatic stk(input slp_op_t op, input logic [15:0] d, input logic [7:0] hi,
		input logic ev, input logic ew, input logic [15:0] ea, input logic [15:0] ed,
		input logic et);
		@(posedge core_clk_i);
		stack_req_i <= '{valid: 1'b1, op: op, data: d, pc_hi: hi};
		@(posedge core_clk_i);
		stack_req_i <= '0;
		#1;
		if (ev) begin
			chk({stack_acc_o.valid, stack_acc_o.write, stack_acc_o.addr, stack_trap_o},
				{ev, ew, ea, et});
			chk(ew ? stack_acc_o.wdata : mem_rdata, ed);
		end else begin
			chk({stack_acc_o.valid, stack_trap_o}, {1'b0, et});
		end
	endtask : stk

	task automatic prg(input logic r, input logic w, input logic dr, input logic [15:0] ea,
		input slp_prog_out_t e);
		@(posedge core_clk_i);
		prog_req_i <= '{tbl_rd: r, tbl_wr: w, data_rd: dr, ea: ea};
		@(posedge core_clk_i);
		prog_req_i <= '0;
		#1;
		if (e.valid) begin
			chk(32'(prog_res_o), 32'(e));
		end else begin
			chk(prog_res_o.valid, 1'b0);
		end
	endtask : prg

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(SLP_OFS_SP, 16'h0800);
		rd(SLP_OFS_TPAGE, 16'h0000);
		rd(4'he, 16'h0000);
		wr(SLP_OFS_LIMIT, 16'h0805);
		rd(SLP_OFS_LIMIT, 16'h0804);
	endtask : t_regs

	task automatic t_push();
		stk(SLP_OP_PUSH, 16'h1111, 8'h00, 1, 1, 16'h0800, 16'h1111, 0);
		stk(SLP_OP_PUSH, 16'h2222, 8'h00, 1, 1, 16'h0802, 16'h2222, 0);
		stk(SLP_OP_PUSH_CALL_HI, 16'hffff, 8'h34, 1, 1, 16'h0804, 16'h0034, 0);
		wr(SLP_OFS_STLOW, 16'h00a5);
		rd(SLP_OFS_STLOW, 16'h00a5);
		stk(SLP_OP_PUSH_EXC_HI, 16'hffff, 8'h56, 1, 1, 16'h0806, 16'ha556, 1);
		rd(SLP_OFS_SP, 16'h0808);
	endtask : t_push

	task automatic t_pop();
		stk(SLP_OP_POP, 16'h0000, 8'h00, 1, 0, 16'h0806, 16'ha556, 0);
		stk(SLP_OP_POP, 16'h0000, 8'h00, 1, 0, 16'h0804, 16'h0034, 0);
		stk(SLP_OP_POP, 16'h0000, 8'h00, 1, 0, 16'h0802, 16'h2222, 0);
		stk(SLP_OP_POP, 16'h0000, 8'h00, 1, 0, 16'h0800, 16'h1111, 0);
		stk(SLP_OP_POP, 16'h0000, 8'h00, 1, 0, 16'h07fe, 16'h5aa5, 1);
		rd(SLP_OFS_SP, 16'h07fe);
		stk(SLP_OP_PUSH, 16'h3333, 8'h00, 1, 1, 16'h07fe, 16'h3333, 1);
		rd(SLP_OFS_SP, 16'h0800);
	endtask : t_pop

	task automatic t_ea();
		wr(SLP_OFS_LIMIT, 16'h1ffe);
		@(posedge core_clk_i);
		stk(SLP_OP_EA, 16'h1ffe, 8'h00, 0, 0, 16'h0000, 16'h0000, 0);
		stk(SLP_OP_EA, 16'h2000, 8'h00, 0, 0, 16'h0000, 16'h0000, 1);
		stk(SLP_OP_EA, 16'h07fe, 8'h00, 0, 0, 16'h0000, 16'h0000, 1);
		stk(SLP_OP_EA, 16'h0800, 8'h00, 0, 0, 16'h0000, 16'h0000, 0);
		rd(SLP_OFS_SP, 16'h0800);
		rd(SLP_OFS_ERR, 16'h0003);
		wr(SLP_OFS_ERR, 16'h0001);
		rd(SLP_OFS_ERR, 16'h0002);
		wr(SLP_OFS_ERR, 16'h0002);
		rd(SLP_OFS_ERR, 16'h0000);
	endtask : t_ea

	task automatic t_table();
		wr(SLP_OFS_TPAGE, 16'h0012);
		prg(1, 0, 0, 16'h1235, '{1, 0, 0, 0, 1, 24'h121234});
		prg(0, 1, 0, 16'h1234, '{1, 0, 0, 0, 0, 24'h121234});
		wr(SLP_OFS_TPAGE, 16'h0085);
		prg(0, 1, 0, 16'h0010, '{1, 1, 0, 1, 0, 24'h850010});
		wr(SLP_OFS_TPAGE, 16'h00ff);
		prg(1, 0, 0, 16'h0002, '{1, 1, 0, 0, 0, 24'hff0002});
		wr(SLP_OFS_TPAGE, 16'h0080);
		prg(1, 0, 0, 16'h0002, '{1, 1, 0, 1, 0, 24'h800002});
	endtask : t_table

	task automatic t_remap();
		wr(SLP_OFS_VPAGE, 16'h00ff);
		wr(SLP_OFS_CORE, 16'h0004);
		rd(SLP_OFS_VPAGE, 16'h00ff);
		rd(SLP_OFS_CORE, 16'h0004);
		prg(0, 0, 1, 16'h8abd, '{1, 0, 1, 0, 1, {1'b0, 8'hff, 15'h0abc}});
		prg(0, 0, 1, 16'h0abc, '{0, 0, 0, 0, 0, 24'h0});
		prg(1, 0, 1, 16'h8002, '{1, 1, 0, 1, 0, 24'h808002});
		@(posedge core_clk_i);
		table_busy_i <= 1'b1;
		prg(0, 0, 1, 16'h8abc, '{0, 0, 0, 0, 0, 24'h0});
		@(posedge core_clk_i);
		table_busy_i <= 1'b0;
		prg(0, 0, 1, 16'h8002, '{1, 0, 1, 0, 0, {1'b0, 8'hff, 15'h0002}});
		wr(SLP_OFS_CORE, 16'h0000);
		prg(0, 0, 1, 16'h8abc, '{0, 0, 0, 0, 0, 24'h0});
	endtask : t_remap

	// back-to-back push at the limit, push past it, then pop
	task automatic t_burst();
		wr(SLP_OFS_LIMIT, 16'h0800);
		@(posedge core_clk_i);
		stack_req_i <= '{valid: 1'b1, op: SLP_OP_PUSH, data: 16'haaaa, pc_hi: 8'h00};
		@(posedge core_clk_i);
		stack_req_i <= '{valid: 1'b1, op: SLP_OP_PUSH, data: 16'hbbbb, pc_hi: 8'h00};
		#1;
		chk({stack_acc_o.addr, stack_acc_o.wdata}, {16'h0800, 16'haaaa});
		chk(stack_trap_o, 1'b0);
		@(posedge core_clk_i);
		stack_req_i <= '{valid: 1'b1, op: SLP_OP_POP, data: 16'h0000, pc_hi: 8'h00};
		#1;
		chk({stack_acc_o.addr, stack_acc_o.wdata}, {16'h0802, 16'hbbbb});
		chk(stack_trap_o, 1'b1);
		@(posedge core_clk_i);
		stack_req_i <= '0;
		#1;
		chk({stack_acc_o.addr, mem_rdata}, {16'h0802, 16'hbbbb});
		chk({stack_acc_o.read, stack_trap_o}, {1'b1, 1'b0});
		rd(SLP_OFS_SP, 16'h0802);
		wr(SLP_OFS_SP, 16'h0901);
		rd(SLP_OFS_SP, 16'h0900);
	endtask : t_burst

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever begin
			#2.5 core_clk_i = ~core_clk_i;
		end
	end

	// watchdog, far beyond the roughly 125 cycles the tests need
	initial begin
		#25000;
		bad_count++;
		conclude();
	end

	initial begin
		bad_count    = 0;
		total_checks = 0;
		reset_n_i    = 1'b0;
		reg_addr_i   = 4'h0;
		reg_wdata_i  = 16'h0000;
		reg_wr_i     = 1'b0;
		reg_rd_i     = 1'b0;
		stack_req_i  = '0;
		prog_req_i   = '0;
		table_busy_i = 1'b0;
		repeat (8) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_push();
		t_pop();
		t_ea();
		t_table();
		t_remap();
		t_burst();
		conclude();
	end
endmodule : stack_limit_and_program_space_addr_bench
